// ===== inc/rmeq_map.svh
`ifndef RMEQ_MAP_SVH
`define RMEQ_MAP_SVH

`define RMEQ_ADDR_MISC 8'h0b
`define RMEQ_ADDR_SWING 8'h0c
`define RMEQ_ADDR_EQ 8'h0d

`define RMEQ_TERM_HI 4
`define RMEQ_TERM_LO 3
`define RMEQ_SPEED_BIT 2
`define RMEQ_RATIO_BIT 1
`define RMEQ_TRAIN_BIT 0
`define RMEQ_DSWING_HI 7
`define RMEQ_DSWING_LO 5
`define RMEQ_CSWING_HI 4
`define RMEQ_CSWING_LO 2
`define RMEQ_TAP_HI 1
`define RMEQ_TAP_LO 0
`define RMEQ_DEQ_HI 5
`define RMEQ_DEQ_LO 3
`define RMEQ_CEQ_HI 2
`define RMEQ_CEQ_LO 1
`define RMEQ_HALFDIS_BIT 0

`define RMEQ_TERM_RST 2'h0
`define RMEQ_SWING_RST 3'h0
`define RMEQ_TAP_RST 2'h0
`define RMEQ_DEQ_RST 3'h0
`define RMEQ_CEQ_RST 2'h0
`define RMEQ_TAP_2DB 2'h1

`define RMEQ_SCDC_ADDR 8'ha8
`define RMEQ_SCDC_RATIO_OFS 8'h20
`define RMEQ_SCDC_RATIO_BIT 1

`define RMEQ_CLK_PERIOD_NS 10
`define RMEQ_HPD_LOW_NS 2000000
`define RMEQ_STRAP_LOAD_CYCLES 2'h3

`endif

// ===== inc/rmeq_pkg.sv
package rmeq_pkg;
  typedef enum logic [2:0] {
    SNP_IDLE,
    SNP_ADDR,
    SNP_SUB,
    SNP_DATA,
    SNP_SKIP
  } rmeq_snoop_state_t;

  typedef logic [7:0] rmeq_byte_t;
endpackage

// ===== logic/rmeq_ddc_snoop.sv
`timescale 1ns/1ns
`default_nettype none
`include "rmeq_map.svh"
module rmeq_ddc_snoop (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Source-side DDC pins, observed only
  input wire logic source_side_ddc_clock_i,
  input wire logic source_side_ddc_data_i,
  // Snooped ratio write
  output logic ratio_write_o,
  output logic ratio_value_o
);
  import rmeq_pkg::*;

  logic scl_s1, scl_s2, scl_s3;
  logic sda_s1, sda_s2, sda_s3;
  logic scl_rise, start_seen, stop_seen, byte_done;
  logic [3:0] bit_cnt;
  rmeq_byte_t shreg, rx_byte, offset;
  rmeq_snoop_state_t state;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_s3 <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_s3 <= 1'b1;
    end else begin
      scl_s1 <= source_side_ddc_clock_i;
      scl_s2 <= scl_s1;
      scl_s3 <= scl_s2;
      sda_s1 <= source_side_ddc_data_i;
      sda_s2 <= sda_s1;
      sda_s3 <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 && !scl_s3;
  assign start_seen = scl_s2 && scl_s3 && sda_s3 && !sda_s2;
  assign stop_seen = scl_s2 && scl_s3 && !sda_s3 && sda_s2;
  assign byte_done = scl_rise && (bit_cnt == 4'h7);
  assign rx_byte = {shreg[6:0], sda_s2};

  // Bit counter runs 0..8; count 8 is the acknowledge slot, which is skipped
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      bit_cnt <= 4'h0;
      shreg <= 8'h00;
    end else if (start_seen || stop_seen) begin
      bit_cnt <= 4'h0;
    end else if (scl_rise) begin
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt != 4'h8) begin
        shreg <= rx_byte;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state <= SNP_IDLE;
      offset <= 8'h00;
      ratio_write_o <= 1'b0;
      ratio_value_o <= 1'b0;
    end else begin
      ratio_write_o <= 1'b0;
      if (stop_seen) begin
        state <= SNP_IDLE;
      end else if (start_seen) begin
        state <= SNP_ADDR;
      end else if (byte_done) begin
        case (state)
          SNP_ADDR: begin
            state <= (rx_byte == `RMEQ_SCDC_ADDR) ? SNP_SUB : SNP_SKIP;
          end
          SNP_SUB: begin
            offset <= rx_byte;
            state <= SNP_DATA;
          end
          SNP_DATA: begin
            if (offset == `RMEQ_SCDC_RATIO_OFS) begin
              ratio_write_o <= 1'b1;
              ratio_value_o <= rx_byte[`RMEQ_SCDC_RATIO_BIT];
            end
            offset <= offset + 8'h01;
          end
          SNP_IDLE, SNP_SKIP: begin
            state <= state;
          end
          default: begin
            state <= SNP_IDLE;
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ===== logic/rmeq_regs.sv
`timescale 1ns/1ns
`default_nettype none
`include "rmeq_map.svh"
module rmeq_regs #(
  parameter int unsigned HPD_LOW_CYCLES = `RMEQ_HPD_LOW_NS / `RMEQ_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register access port from the configuration front end
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  // Strap and hot-plug pins
  input wire logic i2c_enable_strap_i,
  input wire logic [1:0] post_cursor_strap_i,
  input wire logic sink_hotplug_input_i,
  // Source-side DDC pins
  input wire logic source_side_ddc_clock_i,
  input wire logic source_side_ddc_data_i,
  // Device state from the same clock domain
  input wire logic apply_link_settings_strobe_i,
  input wire logic powered_down_i,
  input wire logic clock_present_i,
  input wire logic retimer_mode_i,
  // Applied link settings
  output logic [1:0] transmit_termination_select_o,
  output logic [2:0] data_swing_adjust_o,
  output logic [2:0] clock_swing_adjust_o,
  output logic [1:0] post_cursor_tap_weight_o,
  output logic [2:0] data_eq_code_o,
  output logic [1:0] clock_eq_code_o,
  // Decoded analog settings
  output logic [7:0] data_swing_pct_o,
  output logic [7:0] clock_swing_pct_o,
  output logic deemphasis_2db_o,
  output logic [5:0] data_eq_gain_o,
  output logic [5:0] clock_eq_gain_o,
  output logic clock_half_amplitude_o,
  // Control and status
  output logic ddc_bridge_speed_select_o,
  output logic ddc_training_disable_o,
  output logic clock_ratio_status_o
);
  import rmeq_pkg::*;

  localparam int CW = $clog2(HPD_LOW_CYCLES + 1);

  // Swing adjustment in percent, two's complement
  function automatic rmeq_byte_t swing_pct(input logic [2:0] code);
    case (code)
      3'h1: swing_pct = 8'h07;
      3'h2: swing_pct = 8'h0e;
      3'h3: swing_pct = 8'h15;
      3'h4: swing_pct = 8'he2;
      3'h5: swing_pct = 8'heb;
      3'h6: swing_pct = 8'hf2;
      3'h7: swing_pct = 8'hf9;
      default: swing_pct = 8'h00;
    endcase
  endfunction

  // Data lane gain in half-dB steps
  function automatic logic [5:0] data_eq_gain(input logic [2:0] code, input logic hdmi2);
    case (code)
      3'h1: data_eq_gain = hdmi2 ? 6'h06 : 6'h09;
      3'h2: data_eq_gain = hdmi2 ? 6'h0a : 6'h0d;
      3'h3: data_eq_gain = hdmi2 ? 6'h0f : 6'h11;
      3'h4: data_eq_gain = hdmi2 ? 6'h13 : 6'h15;
      3'h5: data_eq_gain = hdmi2 ? 6'h16 : 6'h18;
      3'h6: data_eq_gain = hdmi2 ? 6'h1a : 6'h1c;
      3'h7: data_eq_gain = hdmi2 ? 6'h1d : 6'h21;
      default: data_eq_gain = 6'h00;
    endcase
  endfunction

  // Clock lane gain in half-dB steps; reserved legacy code gives no gain
  function automatic logic [5:0] clock_eq_gain(input logic [1:0] code, input logic hdmi2);
    case (code)
      2'h1: clock_eq_gain = 6'h03;
      2'h2: clock_eq_gain = 6'h06;
      2'h3: clock_eq_gain = hdmi2 ? 6'h09 : 6'h00;
      default: clock_eq_gain = 6'h00;
    endcase
  endfunction

  logic i2c_en_s1, i2c_en_s2;
  logic [1:0] tap_pin_s1, tap_pin_s2;
  logic hpd_s1, hpd_s2;
  logic [1:0] strap_cnt;
  logic strap_load;
  logic [CW-1:0] hpd_low_cnt;
  logic hpd_timeout;
  logic snoop_wr, snoop_val;
  logic wr_misc, wr_swing, wr_eq, apply_now;

  logic [1:0] staged_term;
  logic speed_sel;
  logic ratio_status;
  logic train_dis;
  logic [2:0] staged_dswing;
  logic [2:0] staged_cswing;
  logic [1:0] staged_tap;
  logic [2:0] staged_deq;
  logic [1:0] staged_ceq;
  logic half_dis;

  assign wr_misc = reg_wr_i && (reg_addr_i == `RMEQ_ADDR_MISC);
  assign wr_swing = reg_wr_i && (reg_addr_i == `RMEQ_ADDR_SWING);
  assign wr_eq = reg_wr_i && (reg_addr_i == `RMEQ_ADDR_EQ);

  // Pin synchronisers
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      i2c_en_s1 <= 1'b0;
      i2c_en_s2 <= 1'b0;
      tap_pin_s1 <= 2'h0;
      tap_pin_s2 <= 2'h0;
      hpd_s1 <= 1'b0;
      hpd_s2 <= 1'b0;
    end else begin
      i2c_en_s1 <= i2c_enable_strap_i;
      i2c_en_s2 <= i2c_en_s1;
      tap_pin_s1 <= post_cursor_strap_i;
      tap_pin_s2 <= tap_pin_s1;
      hpd_s1 <= sink_hotplug_input_i;
      hpd_s2 <= hpd_s1;
    end
  end

  // Straps are copied for the first cycles after release, once synchronised
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      strap_cnt <= 2'h0;
    end else if (strap_cnt != `RMEQ_STRAP_LOAD_CYCLES) begin
      strap_cnt <= strap_cnt + 2'h1;
    end
  end
  assign strap_load = (strap_cnt != `RMEQ_STRAP_LOAD_CYCLES);

  // Hot-plug low timer, saturating
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      hpd_low_cnt <= '0;
    end else if (hpd_s2) begin
      hpd_low_cnt <= '0;
    end else if (hpd_low_cnt != CW'(HPD_LOW_CYCLES)) begin
      hpd_low_cnt <= hpd_low_cnt + CW'(1);
    end
  end
  // Only the second synchroniser stage feeds logic; the first may still be settling
  assign hpd_timeout = !hpd_s2 && (hpd_low_cnt == CW'(HPD_LOW_CYCLES));

  rmeq_ddc_snoop u_snoop (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .source_side_ddc_clock_i(source_side_ddc_clock_i),
    .source_side_ddc_data_i(source_side_ddc_data_i),
    .ratio_write_o(snoop_wr),
    .ratio_value_o(snoop_val)
  );

  // Snoop wins over the timeout clear; a register write forces only when training is off
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ratio_status <= 1'b0;
    end else if (snoop_wr) begin
      ratio_status <= snoop_val;
    end else if (hpd_timeout) begin
      ratio_status <= 1'b0;
    end else if (wr_misc && train_dis) begin
      ratio_status <= reg_wdata_i[`RMEQ_RATIO_BIT];
    end
  end

  // Misc register fields other than the ratio status
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      staged_term <= `RMEQ_TERM_RST;
      speed_sel <= 1'b0;
      train_dis <= 1'b0;
    end else if (wr_misc) begin
      staged_term <= reg_wdata_i[`RMEQ_TERM_HI:`RMEQ_TERM_LO];
      speed_sel <= reg_wdata_i[`RMEQ_SPEED_BIT];
      train_dis <= reg_wdata_i[`RMEQ_TRAIN_BIT];
    end
  end

  // Swing fields; the tap field is kept apart because the strap can own it
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      staged_dswing <= `RMEQ_SWING_RST;
      staged_cswing <= `RMEQ_SWING_RST;
    end else if (wr_swing) begin
      staged_dswing <= reg_wdata_i[`RMEQ_DSWING_HI:`RMEQ_DSWING_LO];
      staged_cswing <= reg_wdata_i[`RMEQ_CSWING_HI:`RMEQ_CSWING_LO];
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      staged_tap <= `RMEQ_TAP_RST;
    end else if (strap_load || !i2c_en_s2) begin
      staged_tap <= tap_pin_s2;
    end else if (wr_swing) begin
      staged_tap <= reg_wdata_i[`RMEQ_TAP_HI:`RMEQ_TAP_LO];
    end
  end

  // Equalization fields and the clock half-amplitude disable
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      staged_deq <= `RMEQ_DEQ_RST;
      staged_ceq <= `RMEQ_CEQ_RST;
      half_dis <= 1'b0;
    end else if (wr_eq) begin
      staged_deq <= reg_wdata_i[`RMEQ_DEQ_HI:`RMEQ_DEQ_LO];
      staged_ceq <= reg_wdata_i[`RMEQ_CEQ_HI:`RMEQ_CEQ_LO];
      half_dis <= reg_wdata_i[`RMEQ_HALFDIS_BIT];
    end
  end

  // Staged link settings reach the lanes on apply, or at once while the link is idle
  assign apply_now = apply_link_settings_strobe_i
    || !hpd_s2
    || powered_down_i
    || !clock_present_i;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      transmit_termination_select_o <= `RMEQ_TERM_RST;
      data_swing_adjust_o <= `RMEQ_SWING_RST;
      clock_swing_adjust_o <= `RMEQ_SWING_RST;
      post_cursor_tap_weight_o <= `RMEQ_TAP_RST;
      data_eq_code_o <= `RMEQ_DEQ_RST;
      clock_eq_code_o <= `RMEQ_CEQ_RST;
      data_swing_pct_o <= 8'h00;
      clock_swing_pct_o <= 8'h00;
    end else if (apply_now) begin
      transmit_termination_select_o <= staged_term;
      data_swing_adjust_o <= staged_dswing;
      clock_swing_adjust_o <= staged_cswing;
      post_cursor_tap_weight_o <= staged_tap;
      data_eq_code_o <= staged_deq;
      clock_eq_code_o <= staged_ceq;
      data_swing_pct_o <= swing_pct(staged_dswing);
      clock_swing_pct_o <= swing_pct(staged_cswing);
    end
  end

  // Decodes that depend on the live clock-ratio or retimer mode
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      deemphasis_2db_o <= 1'b0;
      data_eq_gain_o <= 6'h00;
      clock_eq_gain_o <= 6'h00;
      clock_half_amplitude_o <= 1'b0;
    end else begin
      deemphasis_2db_o <= retimer_mode_i && (post_cursor_tap_weight_o == `RMEQ_TAP_2DB);
      data_eq_gain_o <= data_eq_gain(data_eq_code_o, ratio_status);
      clock_eq_gain_o <= clock_eq_gain(clock_eq_code_o, ratio_status);
      clock_half_amplitude_o <= ratio_status && !half_dis;
    end
  end

  // Register bits seen by the rest of the device, one flop later
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      ddc_bridge_speed_select_o <= 1'b0;
      ddc_training_disable_o <= 1'b0;
      clock_ratio_status_o <= 1'b0;
    end else begin
      ddc_bridge_speed_select_o <= speed_sel;
      ddc_training_disable_o <= train_dis;
      clock_ratio_status_o <= ratio_status;
    end
  end

  // Read port; unmapped offsets and reserved bits read zero
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_rd_i) begin
      case (reg_addr_i)
        `RMEQ_ADDR_MISC: begin
          reg_rdata_o <= {3'h0, staged_term, speed_sel, ratio_status, train_dis};
        end
        `RMEQ_ADDR_SWING: begin
          reg_rdata_o <= {staged_dswing, staged_cswing, staged_tap};
        end
        `RMEQ_ADDR_EQ: begin
          reg_rdata_o <= {2'h0, staged_deq, staged_ceq, half_dis};
        end
        default: begin
          reg_rdata_o <= 8'h00;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== verif/rmeq_regs_properties.sv
`timescale 1ns/1ns
`default_nettype none
module rmeq_regs_properties (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Register port
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_rdata_o,
  // Device state
  input wire logic apply_link_settings_strobe_i,
  input wire logic powered_down_i,
  input wire logic clock_present_i,
  input wire logic sink_hotplug_input_i,
  input wire logic retimer_mode_i,
  // Observed outputs
  input wire logic [1:0] post_cursor_tap_weight_o,
  input wire logic deemphasis_2db_o,
  input wire logic [2:0] data_swing_adjust_o,
  input wire logic [7:0] data_swing_pct_o,
  input wire logic [2:0] data_eq_code_o,
  input wire logic clock_half_amplitude_o,
  input wire logic ddc_bridge_speed_select_o,
  input wire logic clock_ratio_status_o
);
  import rmeq_pkg::*;
  localparam logic [7:0] SW_PCT [8] = '{8'h00, 8'h07, 8'h0e, 8'h15, 8'he2, 8'heb, 8'hf2, 8'hf9};
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  sequence s_rd(a);
    reg_rd_i && reg_addr_i == a;
  endsequence
  // No apply cause for four cycles, raw hot-plug pin included
  sequence s_quiet;
    (!apply_link_settings_strobe_i && !powered_down_i && clock_present_i && sink_hotplug_input_i)[*4];
  endsequence
  property p_unmapped;
    reg_rd_i && !(reg_addr_i inside {8'h0b, 8'h0c, 8'h0d}) |=> reg_rdata_o == 8'h00;
  endproperty
  property p_rsvd_misc;
    s_rd(8'h0b) |=> reg_rdata_o[7:5] == 3'h0;
  endproperty
  property p_rsvd_eq;
    s_rd(8'h0d) |=> reg_rdata_o[7:6] == 2'h0;
  endproperty
  property p_deemph;
    deemphasis_2db_o == $past(retimer_mode_i && post_cursor_tap_weight_o == 2'h1);
  endproperty
  property p_half;
    clock_half_amplitude_o |-> clock_ratio_status_o;
  endproperty
  property p_swing;
    data_swing_pct_o == SW_PCT[data_swing_adjust_o];
  endproperty
  property p_speed;
    reg_wr_i && reg_addr_i == 8'h0b |-> ##2 ddc_bridge_speed_select_o == $past(reg_wdata_i[2], 2);
  endproperty
  property p_hold;
    s_quiet |=> $stable(data_eq_code_o);
  endproperty
  property p_rdhold;
    !reg_rd_i |=> $stable(reg_rdata_o);
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rsvd_misc: assert property (p_rsvd_misc) else $error("reserved misc bits set");
  a_rsvd_eq: assert property (p_rsvd_eq) else $error("reserved eq bits set");
  a_deemph: assert property (p_deemph) else $error("de-emphasis decode wrong");
  a_half: assert property (p_half) else $error("half amplitude without ratio");
  a_swing: assert property (p_swing) else $error("data swing decode wrong");
  a_speed: assert property (p_speed) else $error("speed select not written");
  a_hold: assert property (p_hold) else $error("eq changed without apply");
  a_rdhold: assert property (p_rdhold) else $error("read data changed without read");
endmodule
bind rmeq_regs rmeq_regs_properties i_chk (
  .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
  .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
  .apply_link_settings_strobe_i(apply_link_settings_strobe_i),
  .powered_down_i(powered_down_i), .clock_present_i(clock_present_i),
  .sink_hotplug_input_i(sink_hotplug_input_i), .retimer_mode_i(retimer_mode_i),
  .post_cursor_tap_weight_o(post_cursor_tap_weight_o), .deemphasis_2db_o(deemphasis_2db_o),
  .data_swing_adjust_o(data_swing_adjust_o), .data_swing_pct_o(data_swing_pct_o),
  .data_eq_code_o(data_eq_code_o), .clock_half_amplitude_o(clock_half_amplitude_o),
  .ddc_bridge_speed_select_o(ddc_bridge_speed_select_o), .clock_ratio_status_o(clock_ratio_status_o)
);
`default_nettype wire

// ===== verif/rmeq_ddc_source.sv
`timescale 1ns/1ns
`default_nettype none
module rmeq_ddc_source (
  // Source-side DDC lines, pulled up when released
  output logic scl_o,
  output logic sda_o
);
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  task automatic put(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      scl_o = 1'b0;
      #100 sda_o = b[i];
      #100 scl_o = 1'b1;
      #200;
    end
    // Acknowledge slot: line released, nobody answers here
    scl_o = 1'b0;
    #100 sda_o = 1'b1;
    #100 scl_o = 1'b1;
    #200 scl_o = 1'b0;
    #100;
  endtask
  task automatic write(input logic [7:0] a, input logic [7:0] s, input logic [7:0] d);
    sda_o = 1'b0;
    #200;
    put(a);
    put(s);
    put(d);
    sda_o = 1'b0;
    #100 scl_o = 1'b1;
    #100 sda_o = 1'b1;
    #200;
  endtask
endmodule
`default_nettype wire

// ===== verif/rmeq_regs_test.sv
`timescale 1ns/1ns
`default_nettype none
module rmeq_regs_test;
  import rmeq_pkg::*;
  logic clk_sys_i, sys_rst_i, reg_wr_i, reg_rd_i, i2c_enable_strap_i, sink_hotplug_input_i;
  logic apply_link_settings_strobe_i, powered_down_i, clock_present_i, retimer_mode_i;
  logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, data_swing_pct_o, clock_swing_pct_o;
  logic [1:0] post_cursor_strap_i, transmit_termination_select_o, post_cursor_tap_weight_o, clock_eq_code_o;
  logic [2:0] data_swing_adjust_o, clock_swing_adjust_o, data_eq_code_o;
  logic [5:0] data_eq_gain_o, clock_eq_gain_o;
  logic deemphasis_2db_o, clock_half_amplitude_o, ddc_bridge_speed_select_o;
  logic ddc_training_disable_o, clock_ratio_status_o;
  wire source_side_ddc_clock_i, source_side_ddc_data_i;
  int mismatches = 0;
  int cmp_count = 0;
  int cycles = 0;
  localparam logic [7:0] SW_PCT [8] = '{8'h00, 8'h07, 8'h0e, 8'h15, 8'he2, 8'heb, 8'hf2, 8'hf9};
  rmeq_regs #(.HPD_LOW_CYCLES(20)) i_dut (
    .clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .i2c_enable_strap_i(i2c_enable_strap_i), .post_cursor_strap_i(post_cursor_strap_i),
    .sink_hotplug_input_i(sink_hotplug_input_i),
    .source_side_ddc_clock_i(source_side_ddc_clock_i),
    .source_side_ddc_data_i(source_side_ddc_data_i),
    .apply_link_settings_strobe_i(apply_link_settings_strobe_i),
    .powered_down_i(powered_down_i), .clock_present_i(clock_present_i), .retimer_mode_i(retimer_mode_i),
    .transmit_termination_select_o(transmit_termination_select_o),
    .data_swing_adjust_o(data_swing_adjust_o), .clock_swing_adjust_o(clock_swing_adjust_o),
    .post_cursor_tap_weight_o(post_cursor_tap_weight_o),
    .data_eq_code_o(data_eq_code_o), .clock_eq_code_o(clock_eq_code_o),
    .data_swing_pct_o(data_swing_pct_o), .clock_swing_pct_o(clock_swing_pct_o),
    .deemphasis_2db_o(deemphasis_2db_o), .data_eq_gain_o(data_eq_gain_o),
    .clock_eq_gain_o(clock_eq_gain_o), .clock_half_amplitude_o(clock_half_amplitude_o),
    .ddc_bridge_speed_select_o(ddc_bridge_speed_select_o),
    .ddc_training_disable_o(ddc_training_disable_o),
    .clock_ratio_status_o(clock_ratio_status_o)
  );
  rmeq_ddc_source i_src (.scl_o(source_side_ddc_clock_i), .sda_o(source_side_ddc_data_i));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_i = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk_sys_i);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_i = 1'b0;
    check(reg_rdata_o, exp);
  endtask
  task automatic apply();
    @(negedge clk_sys_i);
    apply_link_settings_strobe_i = 1'b1;
    @(negedge clk_sys_i);
    apply_link_settings_strobe_i = 1'b0;
    waitn(2);
  endtask
  initial begin
    sys_rst_i = 1'b1;
    {reg_wr_i, reg_rd_i, apply_link_settings_strobe_i, powered_down_i} = 4'h0;
    {i2c_enable_strap_i, sink_hotplug_input_i, clock_present_i, retimer_mode_i} = 4'hf;
    reg_addr_i = 8'h00;
    reg_wdata_i = 8'h00;
    post_cursor_strap_i = 2'h0;
    waitn(16);
    sys_rst_i = 1'b0;
    waitn(4);
    rd(8'h0b, 8'h00);
    rd(8'h0c, 8'h00);
    rd(8'h0d, 8'h00);
    rd(8'h0e, 8'h00);
    $display("reset values done");
    wr(8'h0d, 8'hff);
    rd(8'h0d, 8'h3f);
    check(data_eq_code_o, 8'h00);
    apply();
    check(data_eq_gain_o, 8'h21);
    check(clock_eq_gain_o, 8'h00);
    $display("legacy eq done");
    // Auto sleep disable sits outside this block and is taken as set before 400 kbps
    wr(8'h0b, 8'hff);
    rd(8'h0b, 8'h1d);
    wr(8'h0b, 8'hff);
    rd(8'h0b, 8'h1f);
    waitn(2);
    check({ddc_bridge_speed_select_o, ddc_training_disable_o, clock_ratio_status_o}, 8'h07);
    check(data_eq_gain_o, 8'h1d);
    check(clock_eq_gain_o, 8'h09);
    check(clock_half_amplitude_o, 8'h00);
    wr(8'h0d, 8'h3e);
    waitn(3);
    check(clock_half_amplitude_o, 8'h01);
    apply();
    check(transmit_termination_select_o, 8'h03);
    wr(8'h0b, 8'h01);
    rd(8'h0b, 8'h01);
    check(clock_ratio_status_o, 8'h00);
    $display("ratio and eq done");
    for (int i = 0; i < 8; i++) begin
      wr(8'h0c, {i[2:0], ~i[2:0], 2'h1});
      waitn(2);
      check(data_swing_adjust_o, (i == 0) ? 8'h00 : 8'(i - 1));
      apply();
      check({data_swing_adjust_o, clock_swing_adjust_o}, {2'h0, i[2:0], ~i[2:0]});
      check({post_cursor_tap_weight_o, deemphasis_2db_o}, 8'h03);
      check(data_swing_pct_o, SW_PCT[i]);
      check(clock_swing_pct_o, SW_PCT[7 - i]);
    end
    retimer_mode_i = 1'b0;
    waitn(2);
    check(deemphasis_2db_o, 8'h00);
    retimer_mode_i = 1'b1;
    $display("swing done");
    i2c_enable_strap_i = 1'b0;
    waitn(4);
    rd(8'h0c, 8'he0);
    wr(8'h0c, 8'h03);
    rd(8'h0c, 8'h00);
    i2c_enable_strap_i = 1'b1;
    $display("strap done");
    wr(8'h0b, 8'hff);
    waitn(3);
    check(clock_ratio_status_o, 8'h01);
    sink_hotplug_input_i = 1'b0;
    wr(8'h0c, 8'ha4);
    waitn(3);
    check(data_swing_adjust_o, 8'h05);
    check(clock_ratio_status_o, 8'h01);
    waitn(30);
    check(clock_ratio_status_o, 8'h00);
    rd(8'h0b, 8'h1d);
    sink_hotplug_input_i = 1'b1;
    $display("hot-plug done");
    powered_down_i = 1'b1;
    wr(8'h0d, 8'h08);
    waitn(2);
    check(data_eq_code_o, 8'h01);
    powered_down_i = 1'b0;
    clock_present_i = 1'b0;
    wr(8'h0d, 8'h10);
    waitn(2);
    check(data_eq_code_o, 8'h02);
    check(data_eq_gain_o, 8'h0d);
    clock_present_i = 1'b1;
    $display("idle apply done");
    i_src.write(8'ha8, 8'h20, 8'h02);
    waitn(10);
    check(clock_ratio_status_o, 8'h01);
    i_src.write(8'ha0, 8'h20, 8'h00);
    waitn(10);
    check(clock_ratio_status_o, 8'h01);
    i_src.write(8'ha8, 8'h20, 8'h00);
    waitn(10);
    check(clock_ratio_status_o, 8'h00);
    $display("snoop done");
    end_sim();
  end
endmodule
`default_nettype wire
